// file: verilog/ism_start_tx_engine.sv
// i2c master start, repeated start and byte transmit engine with ahb-lite registers
//
// Our own choices: the register addresses and the AHB-Lite register port.
`include "ism_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ism_start_tx_engine
	import ism_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        arst_n_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [7:0]  haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hwdata_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// open-drain i2c lines
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_n_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n_o
);
	// ************************************************************
	// line synchronisers
	// ************************************************************
	ism_lines_t ln_s1_q;
	ism_lines_t ln_q;
	logic       sda_prev_q;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ln_s1_q    <= '1;
			ln_q       <= '1;
			sda_prev_q <= 1'b1;
		end else begin
			ln_s1_q    <= '{scl: scl_i, sda: sda_i};
			ln_q       <= ln_s1_q;
			sda_prev_q <= ln_q.sda;
		end
	end
	wire logic scl_s = ln_q.scl;
	wire logic sda_s = ln_q.sda;
	wire logic start_seen = sda_prev_q & ~sda_s & scl_s;
	// ************************************************************
	// ahb-lite slave decode
	// ************************************************************
	logic       wr_q;
	logic [7:0] wa_q;
	wire logic  acc      = hsel_i & htrans_i[1] & hready_i;
	wire logic  rd_acc   = acc & ~hwrite_i;
	wire logic  wr_baud  = wr_q & (wa_q == `ISM_OFF_ADDR_BAUD);
	wire logic  wr_buf   = wr_q & (wa_q == `ISM_OFF_XFER_BUF);
	wire logic  wr_ctrl  = wr_q & (wa_q == `ISM_OFF_CTRL_TWO);
	wire logic  wr_stat  = wr_q & (wa_q == `ISM_OFF_PORT_STAT);
	wire logic  wr_flags = wr_q & (wa_q == `ISM_OFF_FLAGS);
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	// ************************************************************
	// state and registers
	// ************************************************************
	ism_state_t      st_q, st_d;
	logic [6:0]      baud_q;
	logic [7:0]      buf_q;
	logic [7:0]      shift_q, shift_d;
	logic [3:0]      bit_q, bit_d;
	logic [6:0]      cnt_q, cnt_d;
	logic            run_q, run_d;
	logic [1:0]      ph_q;
	logic            sen_q, repeated_start_enable_bit_q, ack_q, bf_q, sdet_q;
	ism_flags_t      fl_q;
	logic            scl_drv_q, scl_drv_d, sda_drv_q, sda_drv_d;
	logic [3:0]      win_q;
	logic            sen_clr, repeated_start_enable_bit_clr, bf_set, bf_clr, ack_ld, irq_set, bcol_set;
	logic [31:0]     rdata_q;
	wire logic tick      = ph_q[0];
	wire logic tmo       = tick & run_q & (cnt_q == 7'h00);
	wire logic in_start  = (st_q == ISM_ST_WAIT) | (st_q == ISM_ST_HOLD);
	wire logic in_rs     = (st_q == ISM_RS_LOW) | (st_q == ISM_RS_SDA) | (st_q == ISM_RS_SCLH) |
	                       (st_q == ISM_RS_HIGH) | (st_q == ISM_RS_HOLD);
	wire logic in_tx     = (st_q == ISM_TX_LOW) | (st_q == ISM_TX_REL) | (st_q == ISM_TX_HIGH);
	wire logic lock      = in_start | in_rs | sen_q | repeated_start_enable_bit_q;
	wire logic idle      = (st_q == ISM_IDLE) & ~sen_q & ~repeated_start_enable_bit_q;
	wire logic buf_go    = wr_buf & idle;
	wire logic buf_early = wr_buf & in_tx & (win_q != 4'h0);
	wire logic write_collision_flag_set  = wr_buf & ~buf_go;
	// ************************************************************
	// bus registers
	// ************************************************************
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_q    <= 1'b0;
			wa_q    <= 8'h00;
			rdata_q <= 32'h0000_0000;
		end else begin
			wr_q    <= acc & hwrite_i;
			wa_q    <= haddr_i;
			if (rd_acc) begin
				rdata_q <= 32'h0000_0000;
				case (haddr_i)
					`ISM_OFF_ADDR_BAUD: rdata_q[6:0] <= baud_q;
					`ISM_OFF_XFER_BUF:  rdata_q[7:0] <= buf_q;
					`ISM_OFF_CTRL_TWO:  rdata_q[6:0] <= {ack_q, 4'h0, repeated_start_enable_bit_q, sen_q};
					`ISM_OFF_PORT_STAT: rdata_q[3:0] <= {sdet_q, 2'b00, bf_q};
					`ISM_OFF_FLAGS:     rdata_q[2:0] <= {fl_q.write_collision_flag, fl_q.bcol, fl_q.irq};
					default:            rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign hrdata_o = rdata_q;
	// software registers; hardware set beats a same-cycle clear
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			baud_q <= `ISM_RST_BAUD;
			buf_q  <= `ISM_RST_BYTE;
			sen_q  <= 1'b0;
			repeated_start_enable_bit_q <= 1'b0;
			ack_q  <= 1'b0;
			bf_q   <= 1'b0;
			sdet_q <= 1'b0;
			fl_q   <= '0;
		end else begin
			if (wr_baud) baud_q <= hwdata_i[`ISM_BAUD_W-1:0];
			if (buf_go | buf_early) buf_q <= hwdata_i[7:0];
			if (sen_clr) sen_q <= 1'b0;
			else if (wr_ctrl & idle) sen_q <= hwdata_i[`ISM_BIT_SEN];
			if (repeated_start_enable_bit_clr) repeated_start_enable_bit_q <= 1'b0;
			else if (wr_ctrl & ~lock & idle & ~hwdata_i[`ISM_BIT_SEN])
				repeated_start_enable_bit_q <= hwdata_i[`ISM_BIT_REPEATED_START_ENABLE_BIT];
			if (ack_ld) ack_q <= sda_s;
			if (bf_set) bf_q <= 1'b1;
			else if (bf_clr) bf_q <= 1'b0;
			if (start_seen) sdet_q <= 1'b1;
			else if (wr_stat & hwdata_i[`ISM_BIT_SDET]) sdet_q <= 1'b0;
			fl_q.irq  <= irq_set  | (fl_q.irq  & ~(wr_flags & hwdata_i[`ISM_BIT_IRQ]));
			fl_q.bcol <= bcol_set | (fl_q.bcol & ~(wr_flags & hwdata_i[`ISM_BIT_BCOL]));
			fl_q.write_collision_flag <= write_collision_flag_set | (fl_q.write_collision_flag & ~(wr_flags & hwdata_i[`ISM_BIT_WRITE_COLLISION_FLAG]));
		end
	end
	// ************************************************************
	// engine state machine
	// ************************************************************
	always_comb begin
		st_d      = st_q;
		cnt_d     = (tick & run_q & (cnt_q != 7'h00)) ? cnt_q - 7'h01 : cnt_q;
		run_d     = run_q & ~tmo;
		scl_drv_d = scl_drv_q;
		sda_drv_d = sda_drv_q;
		shift_d   = buf_early ? hwdata_i[7:0] : shift_q;
		bit_d     = bit_q;
		sen_clr   = 1'b0;
		repeated_start_enable_bit_clr  = 1'b0;
		bf_set    = buf_go;
		bf_clr    = 1'b0;
		ack_ld    = 1'b0;
		irq_set   = 1'b0;
		bcol_set  = 1'b0;
		case (st_q)
			ISM_IDLE: begin
				if (sen_q) begin
					if (scl_s & sda_s) begin
						cnt_d = baud_q;
						run_d = 1'b1;
						st_d  = ISM_ST_WAIT;
					end else begin
						bcol_set = 1'b1;
						sen_clr  = 1'b1;
					end
				end else if (repeated_start_enable_bit_q) begin
					scl_drv_d = 1'b1;
					st_d      = ISM_RS_LOW;
				end else if (buf_go) begin
					shift_d   = hwdata_i[7:0];
					bit_d     = 4'h0;
					sda_drv_d = ~hwdata_i[7];
					scl_drv_d = 1'b1;
					cnt_d     = baud_q;
					run_d     = 1'b1;
					st_d      = ISM_TX_LOW;
				end
			end
			ISM_ST_WAIT: begin
				if (!scl_s || (tmo && !sda_s)) begin
					bcol_set = 1'b1;
					sen_clr  = 1'b1;
					run_d    = 1'b0;
					st_d     = ISM_IDLE;
				end else if (tmo) begin
					sda_drv_d = 1'b1;
					cnt_d     = baud_q;
					run_d     = 1'b1;
					st_d      = ISM_ST_HOLD;
				end
			end
			ISM_ST_HOLD: begin
				if (tmo) begin
					sen_clr = 1'b1;
					irq_set = 1'b1;
					st_d    = ISM_IDLE;
				end
			end
			ISM_RS_LOW: begin
				if (!scl_s) begin
					cnt_d     = {1'b0, baud_q[`ISM_BAUD_LOW_W-1:0]};
					run_d     = 1'b1;
					sda_drv_d = 1'b0;
					st_d      = ISM_RS_SDA;
				end
			end
			ISM_RS_SDA: begin
				if (tmo) begin
					if (sda_s) begin
						scl_drv_d = 1'b0;
						st_d      = ISM_RS_SCLH;
					end else begin
						bcol_set = 1'b1;
						repeated_start_enable_bit_clr = 1'b1;
						st_d     = ISM_IDLE;
					end
				end
			end
			ISM_RS_SCLH: begin
				if (scl_s) begin
					if (!sda_s) begin
						bcol_set = 1'b1;
						repeated_start_enable_bit_clr = 1'b1;
						st_d     = ISM_IDLE;
					end else begin
						cnt_d = baud_q;
						run_d = 1'b1;
						st_d  = ISM_RS_HIGH;
					end
				end
			end
			ISM_RS_HIGH: begin
				if (!scl_s || !sda_s) begin
					bcol_set = 1'b1;
					repeated_start_enable_bit_clr = 1'b1;
					run_d    = 1'b0;
					st_d     = ISM_IDLE;
				end else if (tmo) begin
					sda_drv_d = 1'b1;
					cnt_d     = baud_q;
					run_d     = 1'b1;
					st_d      = ISM_RS_HOLD;
				end
			end
			ISM_RS_HOLD: begin
				if (tmo) begin
					repeated_start_enable_bit_clr = 1'b1;
					irq_set  = 1'b1;
					st_d     = ISM_IDLE;
				end
			end
			ISM_TX_LOW: begin
				if (tmo) begin
					scl_drv_d = 1'b0;
					st_d      = ISM_TX_REL;
				end
			end
			ISM_TX_REL: begin
				if (scl_s) begin
					cnt_d = baud_q;
					run_d = 1'b1;
					st_d  = ISM_TX_HIGH;
				end
			end
			ISM_TX_HIGH: begin
				if (tmo) begin
					scl_drv_d = 1'b1;
					if (bit_q == `ISM_LAST_BIT) begin
						ack_ld  = 1'b1;
						irq_set = 1'b1;
						st_d    = ISM_IDLE;
					end else begin
						bit_d   = bit_q + 4'h1;
						shift_d = {shift_q[6:0], 1'b0};
						if (bit_q == `ISM_LAST_BIT - 4'h1) begin
							sda_drv_d = 1'b0;
							bf_clr    = 1'b1;
						end else begin
							sda_drv_d = ~shift_q[6];
						end
						cnt_d = baud_q;
						run_d = 1'b1;
						st_d  = ISM_TX_LOW;
					end
				end
			end
			default: begin
				st_d = ISM_IDLE;
			end
		endcase
		if (bcol_set) begin
			scl_drv_d = 1'b0;
			sda_drv_d = 1'b0;
			bf_clr    = 1'b1;
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q      <= ISM_IDLE;
			cnt_q     <= `ISM_RST_BAUD;
			run_q     <= 1'b0;
			ph_q      <= 2'b00;
			scl_drv_q <= 1'b0;
			sda_drv_q <= 1'b0;
			shift_q   <= `ISM_RST_BYTE;
			bit_q     <= 4'h0;
			win_q     <= 4'h0;
		end else begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			run_q     <= run_d;
			ph_q      <= ph_q + 2'b01;
			scl_drv_q <= scl_drv_d;
			sda_drv_q <= sda_drv_d;
			shift_q   <= shift_d;
			bit_q     <= bit_d;
			win_q     <= buf_go ? 4'(`ISM_WRITE_COLLISION_FLAG_WIN_CLKS) : (win_q != 4'h0 ? win_q - 4'h1 : 4'h0);
		end
	end
	// open drain: output low, enable active low while pulling
	assign scl_o      = 1'b0;
	assign sda_o      = 1'b0;
	assign scl_oe_n_o = ~scl_drv_q;
	assign sda_oe_n_o = ~sda_drv_q;
	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	AST_DECREMENT: assert property ((st_q == ISM_TX_LOW) && tick && run_q && (cnt_q != 7'h00) && !tmo
		|=> cnt_q == $past(cnt_q) - 7'h01) else $error("counter did not step");
	AST_BF_SET: assert property (buf_go |=> bf_q && (st_q == ISM_TX_LOW) && scl_drv_q)
		else $error("buffer write did not start byte");
	AST_WRITE_COLLISION_FLAG_START: assert property (wr_buf && (in_start || in_rs) |=> fl_q.write_collision_flag && $stable(buf_q))
		else $error("write during start not refused");
	AST_SUSPEND: assert property ((st_q == ISM_TX_REL) && !scl_s |=> $stable(cnt_q) && !run_q)
		else $error("counter ran while scl stretched");
	AST_START_SDA: assert property ((st_q == ISM_ST_WAIT) && tmo && scl_s && sda_s
		|=> sda_drv_q && (st_q == ISM_ST_HOLD) && (cnt_q == baud_q)) else $error("start edge missing");
	AST_BCOL: assert property ((st_q == ISM_ST_WAIT) && !scl_s |=> fl_q.bcol && (st_q == ISM_IDLE) && !sen_q)
		else $error("start collision not flagged");
	AST_ACK: assert property ((st_q == ISM_TX_HIGH) && tmo && (bit_q == `ISM_LAST_BIT)
		|=> (ack_q == $past(sda_s)) && fl_q.irq ##1 scl_drv_q) else $error("ack not captured");
	AST_RS_END: assert property ((st_q == ISM_RS_HOLD) && tmo |=> !repeated_start_enable_bit_q && fl_q.irq && sda_drv_q && !run_q)
		else $error("repeated start did not finish");
	AST_HOLD_SCL: assert property ((st_q == ISM_IDLE) && scl_drv_q && !sen_q && !repeated_start_enable_bit_q && !wr_buf
		|=> scl_drv_q && !run_q) else $error("scl released while idle");
endmodule : ism_start_tx_engine
`default_nettype wire

// file: verilog/ism_map.svh
// register map, field positions, reset values and timing counts of the start/transmit engine
`ifndef ISM_MAP_SVH
`define ISM_MAP_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define ISM_OFF_ADDR_BAUD   8'h00
`define ISM_OFF_XFER_BUF    8'h04
`define ISM_OFF_CTRL_TWO    8'h08
`define ISM_OFF_PORT_STAT   8'h0C
`define ISM_OFF_FLAGS       8'h10
// ************************************************************
// field positions
// ************************************************************
`define ISM_BIT_SEN         0
`define ISM_BIT_REPEATED_START_ENABLE_BIT        1
`define ISM_BIT_ACK_STATUS_BIT     6
`define ISM_BIT_BF          0
`define ISM_BIT_SDET        3
`define ISM_BIT_IRQ         0
`define ISM_BIT_BCOL        1
`define ISM_BIT_WRITE_COLLISION_FLAG        2
`define ISM_CTRL_LOCK_W     5
`define ISM_CTRL_W          7
`define ISM_BAUD_W          7
`define ISM_BAUD_LOW_W      6
// ************************************************************
// reset values and counts
// ************************************************************
`define ISM_RST_BAUD        7'h00
`define ISM_RST_BYTE        8'h00
`define ISM_LAST_BIT        4'h8
`define ISM_CLK_NS          40
`define ISM_PHASES          4
`define ISM_WRITE_COLLISION_FLAG_WIN_TCY    2
`define ISM_WRITE_COLLISION_FLAG_WIN_CLKS   (`ISM_WRITE_COLLISION_FLAG_WIN_TCY * `ISM_PHASES)
`endif

// file: verilog/ism_pkg.sv
// types shared by the start/transmit engine
`default_nettype none
package ism_pkg;
	typedef enum logic [3:0] {
		ISM_IDLE    = 4'h0,
		ISM_ST_WAIT = 4'h1,
		ISM_ST_HOLD = 4'h3,
		ISM_RS_LOW  = 4'h2,
		ISM_RS_SDA  = 4'h6,
		ISM_RS_SCLH = 4'h7,
		ISM_RS_HIGH = 4'h5,
		ISM_RS_HOLD = 4'h4,
		ISM_TX_LOW  = 4'hC,
		ISM_TX_REL  = 4'hD,
		ISM_TX_HIGH = 4'hF
	} ism_state_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} ism_lines_t;
	typedef struct packed {
		logic irq;
		logic bcol;
		logic write_collision_flag;
	} ism_flags_t;
endpackage : ism_pkg
`default_nettype wire

// file: verification/ism_slave_model.sv
// i2c slave model: byte capture, acknowledge and clock stretching
`timescale 1ns/1ps
`default_nettype none
module ism_slave_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	// resolved lines and controls
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       ack_en_i,
	input  wire logic [3:0] stretch_i,
	// line pulls and captured byte
	output logic            scl_low_o,
	output logic            sda_low_o,
	output logic [7:0]      byte_o
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] cnt_q;
	logic [3:0] hold_q;
	wire        fall_w  = scl_q & ~scl_i;
	wire        rise_w  = ~scl_q & scl_i;
	wire        start_w = scl_q & scl_i & sda_q & ~sda_i;
	// released lines fall back to the pull-up level
	assign scl_low_o = (hold_q != 4'h0);
	assign sda_low_o = ack_en_i & (cnt_q == 4'h9);
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			cnt_q  <= 4'hF;
			hold_q <= 4'h0;
			byte_o <= 8'h00;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			if (start_w) cnt_q <= 4'h0;
			else if (fall_w) cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + ((cnt_q != 4'hF) ? 4'h1 : 4'h0);
			if (rise_w && cnt_q >= 4'h1 && cnt_q <= 4'h8) byte_o <= {byte_o[6:0], sda_i};
			if (fall_w) hold_q <= stretch_i;
			else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
		end
	end
endmodule : ism_slave_model
`default_nettype wire

// file: verification/tb.sv
// self-checking bench of the start/transmit engine
`include "ism_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb import ism_pkg::*;;
	// ************
	// signals
	// ************
	logic        clk, arst_n, hsel, hwrite, ack_en, t_sda, t_scl, hrdy, hresp;
	logic        scl_o, sda_o, scl_oe_n, sda_oe_n, s_scl, s_sda;
	logic [1:0]  htrans;
	logic [7:0]  haddr, got;
	logic [3:0]  stretch;
	logic [31:0] hwdata, hrdata, rd, seed;
	logic [7:0]  offs [4] = '{8'h00, 8'h0C, 8'h10, 8'h20};
	ism_lines_t  ln;
	int          error_cnt, checks, hi_cnt, hi_len;
	assign ln.scl = ~((~scl_oe_n & ~scl_o) | s_scl | t_scl);
	assign ln.sda = ~((~sda_oe_n & ~sda_o) | s_sda | t_sda);
	ism_start_tx_engine dut (.ref_clk_i(clk), .arst_n_i(arst_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hready_i(hrdy), .hwdata_i(hwdata),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .scl_i(ln.scl), .scl_o(scl_o),
		.scl_oe_n_o(scl_oe_n), .sda_i(ln.sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));
	ism_slave_model slv (.clk_i(clk), .arst_n_i(arst_n), .scl_i(ln.scl), .sda_i(ln.sda), .ack_en_i(ack_en),
		.stretch_i(stretch), .scl_low_o(s_scl), .sda_low_o(s_sda), .byte_o(got));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// high time of the last scl pulse, for the high-time check
	always @(posedge clk) begin
		if (ln.scl) hi_cnt <= hi_cnt + 1;
		else begin
			if (hi_cnt != 0) hi_len <= hi_cnt;
			hi_cnt <= 0;
		end
	end
	// ************
	// helpers
	// ************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	function automatic logic exp_ack(input logic ak);
		return ~ak;
	endfunction : exp_ack
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected=%h seen=%h", nm, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (hrdy !== 1'b1 && ++n < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hrdy !== 1'b1 && ++n < 50);
		rd = hrdata;
		check("hresp", hresp, 1'b0);
		if (n >= 50) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask : ahb
	task automatic poll(input logic [7:0] a, input logic [31:0] m);
		int n;
		for (n = 0; n < 400; n++) begin
			ahb(1'b0, a, 32'h0000_0000);
			if ((rd & m) != 0) break;
		end
		if (n == 400) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask : poll
	// start or repeated start, with writes that must be refused meanwhile
	task automatic cond(input logic [31:0] go, input logic [31:0] late);
		ahb(1'b1, `ISM_OFF_ADDR_BAUD, 32'h0000_0090);
		ahb(1'b1, `ISM_OFF_CTRL_TWO, go);
		ahb(1'b1, `ISM_OFF_XFER_BUF, 32'h0000_00A5);
		ahb(1'b1, `ISM_OFF_CTRL_TWO, late);
		poll(`ISM_OFF_FLAGS, 32'h0000_0001);
		check("cond_flags", rd, 32'h0000_0005);
		ahb(1'b0, `ISM_OFF_CTRL_TWO, 32'h0000_0000);
		check("cond_ctrl", rd[1:0], 2'b00);
		ahb(1'b0, `ISM_OFF_PORT_STAT, 32'h0000_0000);
		check("cond_stat", rd, 32'h0000_0008);
		check("cond_lines", ln, 2'b10);
		ahb(1'b1, `ISM_OFF_FLAGS, 32'h0000_0007);
		ahb(1'b1, `ISM_OFF_PORT_STAT, 32'h0000_0008);
		ahb(1'b1, `ISM_OFF_ADDR_BAUD, 32'h0000_0001);
	endtask : cond
	// one byte; gap >= 0 adds a second buffer write, rs tries a repeated start mid-byte
	task automatic send(input logic [7:0] d, input logic ak, input int gap, input logic rs);
		logic [7:0] d2;
		d2 = {d[7], ~d[6:0]};
		seed = xs(seed);
		ack_en <= ak;
		stretch <= {2'b00, seed[1:0]};
		ahb(1'b1, `ISM_OFF_XFER_BUF, {24'h00_0000, d});
		ahb(1'b0, `ISM_OFF_PORT_STAT, 32'h0000_0000);
		check("buffer_full", rd[`ISM_BIT_BF], 1'b1);
		if (gap >= 0) begin
			repeat (gap) @(posedge clk);
			ahb(1'b1, `ISM_OFF_XFER_BUF, {24'h00_0000, d2});
		end
		if (rs) ahb(1'b1, `ISM_OFF_CTRL_TWO, 32'h0000_0002);
		poll(`ISM_OFF_FLAGS, 32'h0000_0001);
		// second write lands six clocks plus gap after the first
		check("byte_seen", got, (gap >= 0 && gap + 6 <= `ISM_WRITE_COLLISION_FLAG_WIN_CLKS) ? d2 : d);
		check("write_collision_flag", rd[`ISM_BIT_WRITE_COLLISION_FLAG], gap >= 0);
		ahb(1'b0, `ISM_OFF_CTRL_TWO, 32'h0000_0000);
		check("ack_status", rd[`ISM_BIT_ACK_STATUS_BIT], exp_ack(ak));
		check("rs_refused", rd[`ISM_BIT_REPEATED_START_ENABLE_BIT], 1'b0);
		ahb(1'b0, `ISM_OFF_PORT_STAT, 32'h0000_0000);
		check("bf_clear", rd, 32'h0000_0000);
		check("scl_held", ln.scl, 1'b0);
		// reload 1 gives four clocks high; sync and tick alignment add one to four
		check("scl_high_len", hi_len >= 5 && hi_len <= 8, 1'b1);
		ahb(1'b1, `ISM_OFF_FLAGS, 32'h0000_0007);
	endtask : send
	// ************
	// main sequence
	// ************
	initial begin
		{arst_n, hsel, hwrite, t_sda, t_scl, htrans, haddr, hwdata} = '0;
		{error_cnt, checks} = '0;
		ack_en = 1'b1;
		stretch = 4'h0;
		seed = 32'h0000_E333;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
		foreach (offs[i]) begin
			ahb(1'b0, offs[i], 32'h0000_0000);
			check("reset_or_unmapped", rd, 32'h0000_0000);
		end
		t_sda <= 1'b1;
		ahb(1'b1, `ISM_OFF_ADDR_BAUD, 32'hFFFF_FF81);
		ahb(1'b0, `ISM_OFF_ADDR_BAUD, 32'h0000_0000);
		check("baud_reload", rd, 32'h0000_0001);
		ahb(1'b1, `ISM_OFF_CTRL_TWO, 32'h0000_0001);
		poll(`ISM_OFF_FLAGS, 32'h0000_0002);
		ahb(1'b0, `ISM_OFF_CTRL_TWO, 32'h0000_0000);
		check("abort_ctrl", rd[`ISM_BIT_SEN], 1'b0);
		check("abort_sda", sda_oe_n, 1'b1);
		ahb(1'b0, `ISM_OFF_PORT_STAT, 32'h0000_0000);
		check("abort_sdet", rd, 32'h0000_0008);
		t_sda <= 1'b0;
		ahb(1'b1, `ISM_OFF_PORT_STAT, 32'h0000_0008);
		ahb(1'b1, `ISM_OFF_FLAGS, 32'h0000_0007);
		// scl pulled low by another master while the start waits
		ahb(1'b1, `ISM_OFF_ADDR_BAUD, 32'h0000_0010);
		ahb(1'b1, `ISM_OFF_CTRL_TWO, 32'h0000_0001);
		repeat (4) @(posedge clk);
		t_scl <= 1'b1;
		poll(`ISM_OFF_FLAGS, 32'h0000_0002);
		check("late_abort_flags", rd, 32'h0000_0002);
		ahb(1'b0, `ISM_OFF_CTRL_TWO, 32'h0000_0000);
		check("late_abort_ctrl", rd[`ISM_BIT_SEN], 1'b0);
		t_scl <= 1'b0;
		ahb(1'b1, `ISM_OFF_FLAGS, 32'h0000_0007);
		cond(32'h0000_0001, 32'h0000_0002);
		send(8'hFF, 1'b1, -1, 1'b0);
		send(8'h00, 1'b0, -1, 1'b0);
		repeat (4) begin
			seed = xs(seed);
			send(seed[7:0], seed[8], -1, seed[9]);
		end
		send(8'h96, 1'b1, 0, 1'b0);
		send(8'h69, 1'b1, 16, 1'b0);
		send(8'hC3, 1'b0, 1, 1'b0);
		send(8'h3C, 1'b1, 3, 1'b0);
		cond(32'h0000_0002, 32'h0000_0001);
		send(8'h5A, 1'b0, -1, 1'b1);
		// mid-byte reset must let both lines go
		ahb(1'b1, `ISM_OFF_XFER_BUF, 32'h0000_00C3);
		repeat (20) @(posedge clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		check("reset_lines", {scl_oe_n, sda_oe_n}, 2'b11);
		arst_n <= 1'b1;
		ahb(1'b0, `ISM_OFF_PORT_STAT, 32'h0000_0000);
		check("reset_stat", rd, 32'h0000_0000);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
